// ===== tb.sv
/*
 * testbench of the write channel: registers, one stalled frame.
 * assumes wr_chan_monitor bound to wr_chan_top, wr_mem_slave beside.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("wrong value at %0t: %h expected %h", $time, g, e); \
    end \
  end

module tb;
  import wr_chan_pkg::*;
  typedef struct {
    logic w; logic [11:0] wa, ra; logic [31:0] d, m, e; logic err;
  } row_t;
  logic         pclk, presetn, psel, penable, pwrite, stall, er;
  logic         in_valid, sts_valid, sts_last;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, sts_data, rd;
  logic [7:0]   eb;
  stream_beat_t sbeat;
  wire logic [31:0] prdata, off_rd;
  wire logic        pready, pslverr, in_ready, sts_ready, aw_valid;
  wire logic        aw_ready, w_valid, w_ready, b_valid, b_ready;
  wire logic [1:0]  b_resp;
  wire logic [6:0]  off_f;
  wire mem_addr_t   aw, off_aw;
  wire mem_beat_t   w, off_w;
  int mismatches, cmp_count, cyc, acc, acc_stall;
  logic [31:0] sts [5] = '{32'h0000_00A0, 32'h0000_00A1, 32'h0000_00A2,
                           32'h0000_00A3, 32'h0001_C050};
  row_t rows [5] = '{
    '{0, 12'h000, 12'h000, 32'h0, 32'hFFFF_FFFF, 32'h0, 0},
    '{1, 12'h00C, 12'h00C, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h3FFF, 0},
    '{1, 12'h008, 12'h008, 32'h1000_0000, 32'hFFFF_FFFF, 32'h1000_0000, 0},
    '{1, 12'h000, 12'h004, 32'h0000_0031, 32'h0000_0007, 32'h1, 0},
    '{1, 12'hFFC, 12'hFFC, 32'h1, 32'h0, 32'h0, 1}};

  // ------------------------------------------------------------
  // design, its excluded twin and the memory slave
  // ------------------------------------------------------------
  wr_chan_top #(.use_status_length_param(1)) wr_chan_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .incoming_stream_port(sbeat),
    .in_valid(in_valid), .in_ready(in_ready), .sts_data(sts_data),
    .sts_valid(sts_valid), .sts_last(sts_last), .sts_ready(sts_ready),
    .aw(aw), .aw_valid(aw_valid), .aw_ready(aw_ready), .w(w),
    .w_valid(w_valid), .w_ready(w_ready), .b_resp(b_resp),
    .b_valid(b_valid), .b_ready(b_ready));
  wr_chan_top #(.write_path_include_param(0)) wr_chan_top_off_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(off_rd),
    .pready(off_f[0]), .pslverr(off_f[1]), .incoming_stream_port(sbeat),
    .in_valid(in_valid), .in_ready(off_f[2]), .sts_data(sts_data),
    .sts_valid(sts_valid), .sts_last(sts_last), .sts_ready(off_f[3]),
    .aw(off_aw), .aw_valid(off_f[4]), .aw_ready(aw_ready), .w(off_w),
    .w_valid(off_f[5]), .w_ready(w_ready), .b_resp(b_resp),
    .b_valid(b_valid), .b_ready(off_f[6]));
  wr_mem_slave wr_mem_slave_inst (
    .pclk(pclk), .presetn(presetn), .stall(stall), .aw(aw),
    .aw_valid(aw_valid), .aw_ready(aw_ready), .w(w), .w_valid(w_valid),
    .w_ready(w_ready), .b_resp(b_resp), .b_valid(b_valid),
    .b_ready(b_ready));

  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer, held until pready, then a free edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, stall, in_valid, sts_valid, sts_last} = '0;
    {paddr, pwdata, sts_data, sbeat} = '0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    `CHK({pready, in_ready, sts_ready, aw_valid, w_valid, b_ready}, 6'h00)
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].wa, rows[i].d, rd, er);
      apb(1'b0, rows[i].ra, '0, rd, er);
      `CHK(rd & rows[i].m, rows[i].e)
      `CHK(er, rows[i].err)
    end
    // status packet, then a frame while memory stalls
    apb(1'b1, 12'h000, 32'h0000_0001, rd, er);
    for (int i = 0; i < 5; i++) begin
      sts_valid <= 1'b1;
      sts_data <= sts[i];
      sts_last <= (i == 4);
      do @(posedge pclk); while (sts_ready !== 1'b1);
    end
    sts_valid <= 1'b0;
    sts_last <= 1'b0;
    sts_data <= ~sts[4];
    stall <= 1'b1;
    fork
      begin
        for (int k = 0; k < 20; k++) begin
          in_valid <= 1'b1;
          sbeat <= '{32'h5500_0000 + k, 4'hF, k == 19};
          do @(posedge pclk); while (in_ready !== 1'b1);
          acc++;
        end
        in_valid <= 1'b0;
        sbeat.data <= ~sbeat.data;
      end
      begin
        repeat (40) @(posedge pclk);
        acc_stall = acc;
        stall <= 1'b0;
      end
    join
    `CHK(acc_stall < 20, 1'b1)
    rd = '0;
    for (int i = 0; i < 300 && rd[1] !== 1'b1; i++)
      apb(1'b0, 12'h004, '0, rd, er);
    `CHK(wr_mem_slave_inst.lens.size(), 2)
    `CHK(wr_mem_slave_inst.lens[0], 32'h0000_000F)
    `CHK(wr_mem_slave_inst.mem.num(), 80)
    for (int b = 0; b < 80; b++) begin
      eb = 8'((32'h5500_0000 + b / 4) >> (8 * (b % 4)));
      `CHK(wr_mem_slave_inst.mem[32'h1000_0000 + b], eb)
    end
    apb(1'b0, 12'h010, '0, rd, er);
    `CHK(rd, 32'h0000_0050)
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'h020 + 12'(4 * i), '0, rd, er);
      `CHK(rd, sts[i])
    end
    apb(1'b1, 12'h004, 32'h0000_0002, rd, er);
    apb(1'b0, 12'h004, '0, rd, er);
    `CHK(rd[1], 1'b0)
    `CHK({off_rd, off_aw, off_w, off_f}, '0)
    `CHK(sts_ready, 1'b1)
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    `CHK({sts_ready, in_ready}, 2'h0)
    apb(1'b0, 12'h000, '0, rd, er);
    `CHK(rd, 32'h0)
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== wr_chan_map.svh
/*
 * constants of the stream-to-memory write channel: build defaults,
 * register offsets, field positions and reset values.
 * assumes inclusion by bare name from the package; the design files use its macros without including it.
 */
`ifndef WR_CHAN_MAP_SVH
`define WR_CHAN_MAP_SVH

// ----------------------------------------------------------------------
// build defaults
// ----------------------------------------------------------------------
`define WRITE_PATH_INCLUDE_DEF   1
`define WRITE_CHANNEL_COUNT_DEF  1
`define MULTICHANNEL_DEF         0
`define MEM_DATA_BITS            32
`define STREAM_DATA_BITS         32
`define WRITE_BURST_LIMIT_DEF    16
`define LENGTH_FIELD_BITS_DEF    14
`define WRITE_REALIGN_DEF        0
`define USE_STATUS_LENGTH_DEF    0
`define STATUS_STREAM_DEF        1
`define FIFO_DEPTH               4
`define USER_WORDS               5

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_CONTROL      12'h000
`define REG_STATUS       12'h004
`define REG_ADDRESS      12'h008
`define REG_LENGTH       12'h00C
`define REG_DONE_BYTES   12'h010
`define REG_CONFIG       12'h014
`define REG_USER_BASE    12'h020

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_RUN_BIT     0
`define CTRL_CHAN_LSB    4
`define STAT_IDLE_BIT    0
`define STAT_DONE_BIT    1
`define STAT_ERR_BIT     2
`define STAT_CHAN_LSB    8
`define CONTROL_RESET    32'h0000_0000
`define LENGTH_RESET     32'h0000_0000

`endif

// ===== wr_chan_monitor.sv
/*
 * checker of the write channel ports: apb answer, burst caps, holds.
 * assumes a bind to every wr_chan_top instance, parameters handed on.
 */
`timescale 1ns/10ps
`default_nettype none

module wr_chan_monitor
  import wr_chan_pkg::*;
#(
  parameter int write_burst_limit_param     = 16,
  parameter int write_path_include_param    = 1,
  parameter int write_realign_include_param = 0
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // stream and status
  input wire logic        in_ready,
  input wire logic        sts_ready,
  // memory write side
  input wire mem_addr_t   aw,
  input wire logic        aw_valid,
  input wire logic        aw_ready,
  input wire mem_beat_t   w,
  input wire logic        w_valid,
  input wire logic        w_ready,
  input wire logic        b_ready
);
  int beat_q;

  // beats taken so far in the current burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat_q <= 0;
    end else if (w_valid && w_ready) begin
      beat_q <= w.last ? 0 : beat_q + 1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_answer: assert property (write_path_include_param != 0 &&
    psel && !penable |=> pready && penable)
    else $error("apb access not answered at once");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_in_answer: assert property (pslverr |-> pready && psel)
    else $error("pslverr outside an answer");
  a_burst_cap: assert property (
    aw_valid |-> aw.len <= write_burst_limit_param - 1)
    else $error("burst length above limit");
  a_beat_cap: assert property (
    w_valid |-> beat_q < write_burst_limit_param)
    else $error("burst beats above limit");
  a_default_cap: assert property (
    write_burst_limit_param == 16 && aw_valid |-> aw.len <= 8'h0F)
    else $error("default burst above sixteen");
  a_word_aligned: assert property (
    write_realign_include_param == 0 && aw_valid |-> aw.addr[1:0] == 2'h0)
    else $error("unaligned burst without realignment");
  a_aw_hold: assert property (aw_valid && !aw_ready |=> aw_valid && $stable(aw))
    else $error("address request dropped or changed");
  a_w_hold: assert property (w_valid && !w_ready |=> w_valid && $stable(w))
    else $error("data beat dropped or changed");
  a_off_quiet: assert property (
    write_path_include_param == 0 |-> {prdata, pready, pslverr, in_ready,
      sts_ready, aw, aw_valid, w, w_valid, b_ready} == '0)
    else $error("excluded channel drives an output");
endmodule

bind wr_chan_top wr_chan_monitor #(
  .write_burst_limit_param(write_burst_limit_param),
  .write_path_include_param(write_path_include_param),
  .write_realign_include_param(write_realign_include_param)
) wr_chan_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_ready(in_ready), .sts_ready(sts_ready), .aw(aw),
  .aw_valid(aw_valid), .aw_ready(aw_ready), .w(w), .w_valid(w_valid),
  .w_ready(w_ready), .b_ready(b_ready)
);
`default_nettype wire

// ===== wr_chan_pkg.sv
/*
 * types of the stream-to-memory write channel.
 * assumes wr_chan_map.svh on the include path.
 */
`include "wr_chan_map.svh"

package wr_chan_pkg;

  // one beat of incoming stream
  typedef struct packed {
    logic [`STREAM_DATA_BITS-1:0]   data;
    logic [`STREAM_DATA_BITS/8-1:0] keep;
    logic                           last;
  } stream_beat_t;

  // one beat of memory write data
  typedef struct packed {
    logic [`MEM_DATA_BITS-1:0]   data;
    logic [`MEM_DATA_BITS/8-1:0] strb;
    logic                        last;
  } mem_beat_t;

  // burst write address request
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  len;
  } mem_addr_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_STATUS, ST_ADDR, ST_DATA, ST_RESP, ST_DONE
  } write_state_t;

endpackage

// ===== wr_chan_top.sv
/*
 * write channel of a dma engine: stream in, burst writes to memory.
 * assumes an apb master for control, an axi4-like write slave and a
 * stream source with an optional five-word status stream.
 */
// Behaviour
// - channel excluded at build drives all its outputs zero, ignores inputs
// - logical channel count is one to sixteen
// - memory write data width is 32 to 1024 bits
// - stream width 8 to 1024 bits, never above memory width
// - memory writes split into bursts no longer than the limit
// - realignment places first stream byte at any byte address
// - realignment allowed only for stream width 64 bits or narrower
// - receive length from status user word four sets bytes written
// - burst limit defaults to 16 beats
// - length and transferred-byte fields default to 14 bits
// - realignment defaults to excluded
// - status packet is kept as user words zero to four of frame
// - length width also limits valid bits of receive length
`timescale 1ns/10ps
`default_nettype none

module wr_chan_top
  import wr_chan_pkg::*;
#(
  parameter int write_path_include_param   = `WRITE_PATH_INCLUDE_DEF,
  parameter int write_channel_count_param  = `WRITE_CHANNEL_COUNT_DEF,
  parameter int multichannel_param         = `MULTICHANNEL_DEF,
  parameter int write_burst_limit_param    = `WRITE_BURST_LIMIT_DEF,
  parameter int length_field_bits_param    = `LENGTH_FIELD_BITS_DEF,
  parameter int write_realign_include_param = `WRITE_REALIGN_DEF,
  parameter int use_status_length_param    = `USE_STATUS_LENGTH_DEF,
  parameter int status_stream_param        = `STATUS_STREAM_DEF
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // incoming stream port
  input  wire stream_beat_t incoming_stream_port,
  input  wire logic         in_valid,
  output logic              in_ready,
  // status stream
  input  wire logic [31:0]  sts_data,
  input  wire logic         sts_valid,
  input  wire logic         sts_last,
  output logic              sts_ready,
  // memory write address
  output mem_addr_t         aw,
  output logic              aw_valid,
  input  wire logic         aw_ready,
  // memory write data
  output mem_beat_t         w,
  output logic              w_valid,
  input  wire logic         w_ready,
  // memory write response
  input  wire logic [1:0]   b_resp,
  input  wire logic         b_valid,
  output logic              b_ready
);

  // ----------------------------------------------------------------------
  // build checks and derived constants
  // ----------------------------------------------------------------------
  localparam int MB = `MEM_DATA_BITS / 8;
  localparam int SB = `STREAM_DATA_BITS / 8;
  localparam bit EN = (write_path_include_param != 0);
  // realign only at 64 bits or under
  localparam bit REALIGN = (write_realign_include_param != 0) &&
                           (`STREAM_DATA_BITS <= 64);
  // one channel unless multichannel is on
  localparam int NCH = (multichannel_param != 0) ?
                       write_channel_count_param : 1;
  localparam int LW = length_field_bits_param;
  localparam int SH = $clog2(MB);

  initial begin
    if (write_channel_count_param < 1 || write_channel_count_param > 16)
      $error("channel count out of range");
    if (`MEM_DATA_BITS < 32 || `MEM_DATA_BITS > 1024)
      $error("memory width out of range");
    if (`STREAM_DATA_BITS > `MEM_DATA_BITS)
      $error("stream wider than memory");
    if (write_burst_limit_param < 2 || write_burst_limit_param > 256)
      $error("burst limit out of range");
  end

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // beats in next burst, capped by the limit
  function automatic logic [8:0] burst_beats(input logic [31:0] words);
    burst_beats = (words > 32'(write_burst_limit_param)) ?
                  9'(write_burst_limit_param) : words[8:0];
  endfunction

  // count of set keep bits
  function automatic logic [7:0] ones(input logic [SB-1:0] k);
    ones = '0;
    for (int i = 0; i < SB; i++) ones = ones + 8'(k[i]);
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [31:0]   ctrl_q, addr_q, len_q, done_q;
  logic          done_f_q, err_f_q;
  logic [31:0]   user_q [`USER_WORDS];
  logic [2:0]    uidx_q;
  write_state_t  st_q;
  logic [31:0]   cur_q;       // current byte address
  logic [31:0]   left_q;      // bytes still to write
  logic [8:0]    beats_q;     // beats left in burst
  logic [SH:0]   off_q;       // byte lane of next byte
  logic [`MEM_DATA_BITS-1:0] acc_q;
  logic [MB-1:0] acc_strb_q;

  wire ch_ok   = {1'b0, ctrl_q[`CTRL_CHAN_LSB +: 4]} < 5'(NCH);
  wire run     = ctrl_q[`CTRL_RUN_BIT] && EN;
  wire apb_acc = psel && penable;
  wire apb_wr  = apb_acc && pwrite;
  wire [11:0] ua = paddr - `REG_USER_BASE;
  wire is_user = (paddr >= `REG_USER_BASE) &&
                 (ua[11:2] < 10'(`USER_WORDS)) && (paddr[1:0] == 2'b00);
  wire mapped  = is_user || paddr == `REG_CONTROL || paddr == `REG_STATUS ||
                 paddr == `REG_ADDRESS || paddr == `REG_LENGTH ||
                 paddr == `REG_DONE_BYTES || paddr == `REG_CONFIG;
  wire [31:0] lmask = (32'h1 << LW) - 32'h1;

  // read mux
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0;
    case (paddr)
      `REG_CONTROL:    rd_d = ctrl_q;
      `REG_STATUS:     rd_d = {20'h0, 4'(ctrl_q[`CTRL_CHAN_LSB +: 4]),
                               5'h0, err_f_q, done_f_q, st_q == ST_IDLE};
      `REG_ADDRESS:    rd_d = addr_q;
      `REG_LENGTH:     rd_d = len_q;
      `REG_DONE_BYTES: rd_d = done_q & lmask;
      `REG_CONFIG:     rd_d = {8'(write_burst_limit_param), 8'(NCH),
                               8'(LW), 7'h0, REALIGN};
      default:         rd_d = is_user ? user_q[ua[4:2]] : 32'h0;
    endcase
  end

  // apb answers in the access cycle; outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= EN && psel && !penable;
      prdata  <= (psel && !penable && EN) ? rd_d : 32'h0;
      pslverr <= EN && psel && !penable && !mapped;
    end
  end

  // software writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CONTROL_RESET;
      addr_q <= 32'h0;
      len_q  <= `LENGTH_RESET;
    end else if (apb_wr && pready && EN) begin
      if (paddr == `REG_CONTROL) ctrl_q <= pwdata;
      if (paddr == `REG_ADDRESS) addr_q <= pwdata;
      if (paddr == `REG_LENGTH)  len_q  <= pwdata & lmask;
    end
  end

  // ----------------------------------------------------------------------
  // input fifo
  // ----------------------------------------------------------------------
  stream_beat_t f_out;
  logic         f_valid, f_ready, f_in_ready;
  wr_fifo #(.WIDTH($bits(stream_beat_t)), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (in_valid && in_ready && EN),
    .in_ready  (f_in_ready),
    .in_data   (incoming_stream_port),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_out),
    .clear     (!EN)
  );

  // ----------------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------------
  wire start    = run && ch_ok && st_q == ST_IDLE && !done_f_q;
  wire need_sts = (status_stream_param != 0);
  wire [31:0] rx_len = sts_data & lmask;
  // source keeps to reported length, so no extra beats are expected
  wire [7:0]  nbytes = ones(f_out.keep);
  wire [SH:0] fill   = off_q + (SH+1)'(nbytes);
  wire        beat_full = (fill >= (SH+1)'(MB)) ||
                          ((32'(nbytes) >= left_q) && f_valid);
  wire        take  = st_q == ST_DATA && f_valid && !w_valid;
  wire        w_go  = w_valid && w_ready;
  wire [31:0] base_aligned = REALIGN ? addr_q :
                             {addr_q[31:SH], SH'(0)};
  wire [31:0] words_left = (left_q + 32'(cur_q[SH-1:0]) + 32'(MB-1)) >> SH;

  assign f_ready = take;

  // merge stream bytes into the memory word at the running lane
  logic [`MEM_DATA_BITS-1:0] acc_d;
  logic [MB-1:0]             strb_d;
  always_comb begin
    acc_d  = acc_q;
    strb_d = acc_strb_q;
    for (int i = 0; i < SB; i++) begin
      if (f_out.keep[i] && (32'(off_q) + 32'(i) < 32'(MB))) begin
        acc_d[(32'(off_q)+i)*8 +: 8] = f_out.data[i*8 +: 8];
        strb_d[32'(off_q)+i]         = 1'b1;
      end
    end
  end

  // state and datapath
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= ST_IDLE;
      cur_q      <= 32'h0;
      left_q     <= 32'h0;
      beats_q    <= 9'h0;
      off_q      <= '0;
      acc_q      <= '0;
      acc_strb_q <= '0;
      done_q     <= 32'h0;
      done_f_q   <= 1'b0;
      err_f_q    <= 1'b0;
      uidx_q     <= 3'h0;
      aw         <= '0;
      aw_valid   <= 1'b0;
      w          <= '0;
      w_valid    <= 1'b0;
      b_ready    <= 1'b0;
      sts_ready  <= 1'b0;
      in_ready   <= 1'b0;
      for (int i = 0; i < `USER_WORDS; i++) user_q[i] <= 32'h0;
    end else begin
      in_ready <= f_in_ready && EN && !(in_valid && in_ready);
      // software clears done by writing status; a finishing frame wins
      if (apb_wr && pready && paddr == `REG_STATUS && st_q != ST_DONE)
        done_f_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            cur_q   <= base_aligned;
            off_q   <= (SH+1)'(base_aligned[SH-1:0]);
            left_q  <= len_q;
            done_q  <= 32'h0;
            err_f_q <= 1'b0;
            uidx_q  <= 3'h0;
            sts_ready <= need_sts;
            st_q    <= need_sts ? ST_STATUS : ST_ADDR;
          end
        end
        ST_STATUS: begin
          // status packet becomes user words zero to four
          if (sts_valid && sts_ready) begin
            if (uidx_q < 3'(`USER_WORDS)) user_q[uidx_q] <= sts_data;
            if (uidx_q == 3'd4 && use_status_length_param != 0)
              left_q <= rx_len;
            uidx_q <= uidx_q + 3'h1;
            if (sts_last) begin
              sts_ready <= 1'b0;
              st_q      <= ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          if (left_q == 32'h0) begin
            st_q <= ST_DONE;
          end else if (!aw_valid) begin
            aw.addr  <= {cur_q[31:SH], SH'(0)};
            aw.len   <= 8'(burst_beats(words_left) - 9'h1);
            beats_q  <= burst_beats(words_left);
            aw_valid <= 1'b1;
          end else if (aw_ready) begin
            aw_valid <= 1'b0;
            st_q     <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (take) begin
            if (beat_full || f_out.last) begin
              w.data     <= acc_d;
              w.strb     <= strb_d;
              w.last     <= (beats_q == 9'h1);
              w_valid    <= 1'b1;
              acc_q      <= '0;
              acc_strb_q <= '0;
              off_q      <= '0;
            end else begin
              acc_q      <= acc_d;
              acc_strb_q <= strb_d;
              off_q      <= fill;
            end
            left_q <= (32'(nbytes) >= left_q) ? 32'h0 :
                      left_q - 32'(nbytes);
            done_q <= done_q + 32'(nbytes);
          end
          if (w_go) begin
            w_valid <= 1'b0;
            beats_q <= beats_q - 9'h1;
            cur_q   <= {cur_q[31:SH], SH'(0)} + 32'(MB);
            if (w.last) begin
              b_ready <= 1'b1;
              st_q    <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          if (b_valid) begin
            b_ready <= 1'b0;
            if (b_resp != 2'b00) err_f_q <= 1'b1;
            st_q <= ST_ADDR;
          end
        end
        ST_DONE: begin
          done_f_q <= 1'b1;
          st_q     <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== wr_fifo.sv
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module wr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // flush
  input  wire logic             clear
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // honest full and empty from the count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // pointers and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clear) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage
  always_ff @(posedge pclk) begin
    if (push) mem_q[wr_q] <= in_data;
  end

endmodule

`default_nettype wire

// ===== wr_mem_slave.sv
/*
 * memory write slave: takes bursts, keeps bytes, one response a burst.
 * assumes one clock; stall holds both readies low.
 */
`timescale 1ns/10ps
`default_nettype none

module wr_mem_slave
  import wr_chan_pkg::*;
(
  // clock, reset, stall
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      stall,
  // write address and data
  input  wire mem_addr_t aw,
  input  wire logic      aw_valid,
  output logic           aw_ready,
  input  wire mem_beat_t w,
  input  wire logic      w_valid,
  output logic           w_ready,
  // write response
  output logic [1:0]     b_resp,
  output logic           b_valid,
  input  wire logic      b_ready
);
  logic [7:0]  mem [logic [31:0]];
  logic [31:0] lens [$];
  logic [31:0] aq [$];
  int          pend_q, bn_q, beat_q;

  // readies and response; idle response shows a non-okay code
  assign aw_ready = !stall;
  assign w_ready  = !stall && pend_q > 0;
  assign b_valid  = bn_q > 0;
  assign b_resp   = b_valid ? 2'h0 : 2'h3;

  // take addresses, store strobed bytes, count responses owed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 0;
      bn_q <= 0;
      beat_q <= 0;
      aq.delete();
    end else begin
      if (aw_valid && aw_ready) begin
        aq.push_back(aw.addr);
        lens.push_back(32'(aw.len));
      end
      if (w_valid && w_ready) begin
        for (int i = 0; i < 4; i++)
          if (w.strb[i]) mem[aq[0] + 4 * beat_q + i] = w.data[8*i +: 8];
        beat_q <= w.last ? 0 : beat_q + 1;
        if (w.last) void'(aq.pop_front());
      end
      pend_q <= pend_q + int'(aw_valid && aw_ready)
                - int'(w_valid && w_ready && w.last);
      bn_q <= bn_q + int'(w_valid && w_ready && w.last)
              - int'(b_valid && b_ready);
    end
  end
endmodule
`default_nettype wire
